// [hdl/burst_sram_regs.svh]
// Widths, sizes and reset values for the pipelined burst SRAM port
// Functional notes
// [R1] Output enable low drives the data pins, acting without a clock edge.
// [R2] Output enable high floats the data pins and treats them as inputs.
// [R3] First clock of a read after deselect ignores output enable.
// [R4] Burst advance sampled low during a burst steps the burst address.
// [R5] Processor strobe low latches the full address and loads low bits into counter.
// [R6] Controller strobe low latches the full address and loads low bits into counter.
// [R7] When both strobes are low only the processor strobe is acted on.
// [R8] Processor strobe is ignored while the first chip select is high.
// [R9] Sleep input high quiets the port and keeps memory contents.
// [R10] Data pins used as inputs are captured into a data register.
// [R11] Read data appears one cycle after its address edge.
// [R12] Burst order strap low gives linear order, high or floating interleaved.
// [R13] The system keeps the burst order strap static during operation.
// [R14] Burst counter is two bits, wraps, starts at low address bits.
// [R15] Device is selected only when all three chip selects are active.
// [R16] Advance after the fourth word wraps to the burst's first position.
`ifndef BURST_SRAM_REGS_SVH
`define BURST_SRAM_REGS_SVH
`define ADDR_W 16
`define DATA_W 32
`define BYTE_N 4
`define BURST_W 2
`define MEM_WORDS 65536
`define BURST_RST 2'h0
`define DATA_RST 32'h0000_0000
`define ADDR_RST 16'h0000
`endif

// [hdl/burst_sram_pkg.sv]
// Types shared by the burst SRAM port
`include "burst_sram_regs.svh"
package burst_sram_pkg;
   typedef logic [`ADDR_W-1:0] addr_t;
   typedef logic [`DATA_W-1:0] data_t;
   typedef logic [`BYTE_N-1:0] byte_en_t;
   typedef logic [`BURST_W-1:0] burst_t;
   typedef struct packed {
      logic proc_addr_strobe_n;
      logic ctrl_addr_strobe_n;
      logic burst_step_n;
      logic chip_sel_first_n;
      logic chip_sel_second;
      logic chip_sel_third_n;
   } ctrl_pins_t;
   typedef struct packed {
      logic global_wr_n;
      logic byte_wr_en_n;
      byte_en_t byte_sel_n;
   } write_pins_t;
   typedef enum logic [1:0] {
      ST_DESEL,
      ST_READ,
      ST_WRITE
   } acc_state_t;
endpackage

// [hdl/burst_order_counter.sv]
// Two-bit wrapping burst counter with linear or interleaved order
`timescale 1ns/10ps
`include "burst_sram_regs.svh"
module burst_order_counter (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Control
   input wire logic load,
   input wire logic step,
   input wire logic linear,
   input wire burst_sram_pkg::burst_t load_val,
   // Current low address
   output burst_sram_pkg::burst_t cur
);
   import burst_sram_pkg::*;

   burst_t start_q;
   burst_t offset_q;
   burst_t lin_addr;

   // [R12] order select
   assign lin_addr = burst_t'(start_q + offset_q);
   assign cur = linear ? lin_addr : (start_q ^ offset_q);

   // [R14] [R16] load and wrap
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         start_q <= `BURST_RST;
         offset_q <= `BURST_RST;
      end else if (load) begin
         start_q <= load_val;
         offset_q <= `BURST_RST;
      end else if (step) begin
         offset_q <= burst_t'(offset_q + 2'h1);
      end
   end

   a_counter_load: assert property (@(posedge core_clk) disable iff (!nrst) // [R14]
      load |=> cur == $past(load_val))
      else $error("burst counter did not load start address");

   a_burst_wrap: assert property (@(posedge core_clk) disable iff (!nrst) // [R16]
      (step && !load && offset_q == 2'h3) |=> (offset_q == 2'h0 && cur == start_q))
      else $error("burst did not wrap to first position");

   a_order_interleave: assert property (@(posedge core_clk) disable iff (!nrst) // [R12]
      (step && !load && !linear && $stable(linear)) |=>
      cur == ($past(start_q) ^ burst_t'($past(offset_q) + 2'h1)))
      else $error("interleaved order step wrong");
endmodule

// [hdl/burst_sram_port.sv]
// Pipelined burst SRAM port: strobes, burst counter, data pins and core
`timescale 1ns/10ps
`include "burst_sram_regs.svh"
module burst_sram_port (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Address and synchronous controls
   input wire burst_sram_pkg::addr_t addr,
   input wire burst_sram_pkg::ctrl_pins_t ctrl,
   input wire burst_sram_pkg::write_pins_t wr,
   // Asynchronous and static controls
   input wire logic output_enable_n,
   input wire logic sleep_request,
   input wire logic burst_order,
   // Data pins
   input wire burst_sram_pkg::data_t dq_in,
   output burst_sram_pkg::data_t dq_out,
   output logic dq_oe,
   // Status
   output logic sleeping
);
   import burst_sram_pkg::*;

   acc_state_t state_q;
   acc_state_t state_d;
   addr_t addr_q;
   data_t rdata_q;
   data_t data_q;
   addr_t wr_addr_q;
   byte_en_t wr_be_q;
   logic wr_pend_q;
   logic out_en_q;
   logic linear_q;
   logic sleep_s1_q;
   logic sleep_s2_q;
   logic sleep_s3_q;
   logic sleep_q;

   wire logic sel;
   wire logic proc_take;
   wire logic ctrl_take;
   wire logic strobe;
   wire logic start;
   wire logic desel;
   wire logic active;
   wire logic step;
   wire logic wr_any;
   wire logic wr_take;
   wire byte_en_t wr_be;
   wire burst_t burst_lo;
   wire addr_t cur_addr;
   wire addr_t wr_addr_now;
   wire logic bypass;
   data_t rd_word;
   logic out_en_d;

   // [R15] joint chip select
   assign sel = !ctrl.chip_sel_first_n && ctrl.chip_sel_second && !ctrl.chip_sel_third_n;
   // [R8] first select gates processor strobe
   assign proc_take = !ctrl.proc_addr_strobe_n && !ctrl.chip_sel_first_n;
   // [R7] processor strobe has priority
   assign ctrl_take = !ctrl.ctrl_addr_strobe_n && !proc_take;
   assign strobe = (proc_take || ctrl_take) && !sleep_q;
   assign start = strobe && sel;
   assign desel = strobe && !sel;
   assign active = state_q != ST_DESEL;

   // Write decode; global write overrides byte selects
   assign wr_be = !wr.global_wr_n ? {`BYTE_N{1'b1}} :
                  (!wr.byte_wr_en_n ? ~wr.byte_sel_n : {`BYTE_N{1'b0}});
   assign wr_any = |wr_be;
   // Processor-started access ignores write pins in its first cycle
   assign wr_take = !sleep_q && wr_any &&
                    ((ctrl_take && sel) || (active && !strobe));

   // [R4] advance only inside a burst, never on a strobe edge
   assign step = active && !ctrl.burst_step_n && !strobe && !sleep_q;

   burst_order_counter i_burst_order_counter (
      .core_clk(core_clk),
      .nrst(nrst),
      .load(start),
      .step(step),
      .linear(linear_q),
      .load_val(addr[`BURST_W-1:0]),
      .cur(burst_lo)
   );

   assign cur_addr = {addr_q[`ADDR_W-1:`BURST_W], burst_lo};
   assign wr_addr_now = (ctrl_take && sel) ? addr : cur_addr;
   assign bypass = wr_pend_q && (wr_addr_q == cur_addr);

   // Late-write bypass per byte, so a read right behind a write sees it
   genvar gi;
   generate
      for (gi = 0; gi < `BYTE_N; gi++) begin : g_byte
         // One array per lane, so each lane has a single writer
         logic [7:0] lane_q [0:`MEM_WORDS-1];
         wire logic [7:0] lane_rd;
         assign lane_rd = lane_q[cur_addr];
         always_comb begin
            rd_word[gi*8 +: 8] = (bypass && wr_be_q[gi]) ? data_q[gi*8 +: 8] : lane_rd;
         end
         always_ff @(posedge core_clk) begin
            if (wr_pend_q && wr_be_q[gi]) begin
               lane_q[wr_addr_q] <= data_q[gi*8 +: 8];
            end
         end
      end
   endgenerate

   // Access state; sleep forces a deselect, core keeps its contents
   always_comb begin
      state_d = state_q;
      if (sleep_q) begin
         state_d = ST_DESEL;
      end else if (start) begin
         state_d = (ctrl_take && wr_any) ? ST_WRITE : ST_READ;
      end else if (desel) begin
         state_d = ST_DESEL;
      end else begin
         unique case (state_q)
            ST_DESEL: state_d = ST_DESEL;
            ST_READ, ST_WRITE: state_d = wr_any ? ST_WRITE : ST_READ;
         endcase
      end
   end

   // [R3] drive only if already reading before this edge
   assign out_en_d = (state_q == ST_READ) && (state_d == ST_READ);

   // [R5] [R6] address register load
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         addr_q <= `ADDR_RST;
      end else if (start) begin
         addr_q <= addr;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         state_q <= ST_DESEL;
         out_en_q <= 1'b0;
      end else begin
         state_q <= state_d;
         out_en_q <= out_en_d;
      end
   end

   // [R11] output register, one cycle behind the address
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         rdata_q <= `DATA_RST;
      end else if (state_q == ST_READ) begin
         rdata_q <= rd_word;
      end
   end

   // [R10] input data register
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         data_q <= `DATA_RST;
      end else if (!dq_oe) begin
         data_q <= dq_in;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= `ADDR_RST;
         wr_be_q <= {`BYTE_N{1'b0}};
      end else begin
         wr_pend_q <= wr_take;
         wr_addr_q <= wr_addr_now;
         wr_be_q <= wr_be;
      end
   end

   // [R12] strap caught in reset; assumed static afterwards ([R13])
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         linear_q <= burst_order == 1'b0;
      end
   end

   // [R9] sleep synchroniser; change taken when stages two and three agree
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         sleep_s1_q <= 1'b0;
         sleep_s2_q <= 1'b0;
         sleep_s3_q <= 1'b0;
         sleep_q <= 1'b0;
      end else begin
         sleep_s1_q <= sleep_request;
         sleep_s2_q <= sleep_s1_q;
         sleep_s3_q <= sleep_s2_q;
         if (sleep_s2_q == sleep_s3_q) begin
            sleep_q <= sleep_s3_q;
         end
      end
   end

   assign dq_out = rdata_q;
   assign sleeping = sleep_q;
   // [R1] [R2] [R9] pin direction is combinational, not clocked
   assign dq_oe = out_en_q && !output_enable_n && !sleep_request;

   sequence s_fresh_read;
      state_q == ST_DESEL && start && !wr_any && !ctrl_take;
   endsequence

   a_oe_drives: assert property (@(posedge core_clk) disable iff (!nrst) // [R1]
      (out_en_q && !output_enable_n && !sleep_request) |-> dq_oe)
      else $error("data pins not driven with enable low");

   a_oe_floats: assert property (@(posedge core_clk) disable iff (!nrst) // [R2]
      output_enable_n |-> !dq_oe)
      else $error("data pins driven with enable high");

   a_first_read_mask: assert property (@(posedge core_clk) disable iff (!nrst) // [R3]
      s_fresh_read |=> !dq_oe)
      else $error("enable not masked in first read cycle");

   a_proc_latch: assert property (@(posedge core_clk) disable iff (!nrst) // [R5]
      (proc_take && sel && !sleep_q) |=> (addr_q == $past(addr) && burst_lo == $past(addr[1:0])))
      else $error("processor strobe did not latch address");

   a_ctrl_latch: assert property (@(posedge core_clk) disable iff (!nrst) // [R6]
      (ctrl_take && sel && !sleep_q) |=> (addr_q == $past(addr) && burst_lo == $past(addr[1:0])))
      else $error("controller strobe did not latch address");

   a_proc_priority: assert property (@(posedge core_clk) disable iff (!nrst) // [R7]
      (!ctrl.proc_addr_strobe_n && !ctrl.ctrl_addr_strobe_n && sel && !sleep_q && wr_any)
      |=> !wr_pend_q)
      else $error("controller strobe acted beside processor strobe");

   a_ce1_blocks: assert property (@(posedge core_clk) disable iff (!nrst) // [R8]
      (ctrl.chip_sel_first_n && ctrl.ctrl_addr_strobe_n) |=> $stable(addr_q))
      else $error("processor strobe taken with first select high");

   a_burst_step: assert property (@(posedge core_clk) disable iff (!nrst) // [R4]
      (step && linear_q) |=> burst_lo == burst_t'($past(burst_lo) + 2'h1))
      else $error("burst address did not advance");

   a_sleep_quiet: assert property (@(posedge core_clk) disable iff (!nrst) // [R9]
      sleep_q |=> (state_q == ST_DESEL && !wr_pend_q))
      else $error("port active while asleep");

   a_data_capture: assert property (@(posedge core_clk) disable iff (!nrst) // [R10]
      !dq_oe |=> data_q == $past(dq_in))
      else $error("input data not captured");

   a_read_latency: assert property (@(posedge core_clk) disable iff (!nrst) // [R11]
      (state_q == ST_READ) |=> dq_out == $past(rd_word))
      else $error("read data not one cycle after address");
endmodule

// [verification/sram_host_model.sv]
// Host-side model that resolves the shared data wire
`timescale 1ns/10ps
module sram_host_model (
   // Clock
   input wire logic core_clk,
   // Port side of the wire
   input wire burst_sram_pkg::data_t dq_out,
   input wire logic dq_oe,
   // Host side of the wire
   input wire logic drv_en,
   input wire burst_sram_pkg::data_t drv_val,
   // Resolved wire
   output burst_sram_pkg::data_t dq_in
);
   import burst_sram_pkg::*;
   data_t last_q = 32'h0000_0000;
   // Released wire flips every cycle so a stale value never passes
   assign dq_in = dq_oe ? dq_out : (drv_en ? drv_val : ~last_q);
   always_ff @(posedge core_clk) begin
      last_q <= dq_in;
   end
endmodule

// [verification/test_burst_sram_port.sv]
// Self-checking bench for the burst SRAM port
`timescale 1ns/10ps
module test_burst_sram_port;
   import burst_sram_pkg::*;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   addr_t addr = 16'h0000;
   ctrl_pins_t ctrl = 6'h3d;
   write_pins_t wr = 6'h3f;
   logic output_enable_n = 1'b1;
   logic sleep_request = 1'b0;
   logic burst_order = 1'b0;
   logic drv_en = 1'b0;
   data_t drv_val = 32'h0000_0000;
   data_t dq_in;
   data_t dq_out;
   logic dq_oe;
   logic sleeping;
   int failures = 0;
   int cmp_count = 0;
   int cycles = 0;
   localparam addr_t BASE = 16'h0020;

   burst_sram_port i_burst_sram_port (.core_clk(core_clk), .nrst(nrst), .addr(addr),
      .ctrl(ctrl), .wr(wr), .output_enable_n(output_enable_n),
      .sleep_request(sleep_request), .burst_order(burst_order), .dq_in(dq_in),
      .dq_out(dq_out), .dq_oe(dq_oe), .sleeping(sleeping));
   sram_host_model i_sram_host_model (.core_clk(core_clk), .dq_out(dq_out), .dq_oe(dq_oe),
      .drv_en(drv_en), .drv_val(drv_val), .dq_in(dq_in));

   always #2.5 core_clk = ~core_clk;

   // Whole run needs about seventy cycles
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 1000) begin
         failures++;
         conclude();
      end
   end

   task automatic conclude();
      $display("counts: %0d compares, %0d failures", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic tick();
      @(posedge core_clk);
      #1;
   endtask

   task automatic check_data(data_t got, data_t exp, string what);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   task automatic check_bit(logic got, logic exp, string what);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: %s got %b want %b", $time, what, got, exp);
      end
   endtask

   task automatic sel(logic on);
      ctrl.chip_sel_first_n = !on;
      ctrl.chip_sel_second = on;
      ctrl.chip_sel_third_n = !on;
   endtask

   function automatic data_t pat(addr_t a);
      return {16'hc0de, a};
   endfunction

   function automatic logic [1:0] nth(logic [1:0] s, logic [1:0] i);
      return burst_order ? (s ^ i) : (s + i);
   endfunction

   // Deselect through the controller strobe with selects inactive
   task automatic deselect();
      sel(1'b0);
      ctrl.ctrl_addr_strobe_n = 1'b0;
      tick();
      ctrl.ctrl_addr_strobe_n = 1'b1;
      check_bit(dq_oe, 1'b0, "pins after deselect");
   endtask

   task automatic do_reset(logic order);
      nrst = 1'b0;
      burst_order = order;
      repeat (4) tick();
      check_data(dq_out, 32'h0000_0000, "reset data");
      check_bit(dq_oe, 1'b0, "reset enable");
      nrst = 1'b1;
   endtask

   task automatic t_writes();
      sel(1'b1);
      wr.global_wr_n = 1'b0;
      drv_en = 1'b1;
      ctrl.ctrl_addr_strobe_n = 1'b0;
      for (int i = 0; i < 4; i++) begin
         addr = BASE + addr_t'(i);
         drv_val = pat(addr);
         tick();
      end
      // Both strobes: processor wins, so write pins on this edge are dropped
      addr = BASE + 16'h0001;
      drv_val = 32'hdead_beef;
      ctrl.proc_addr_strobe_n = 1'b0;
      tick();
      ctrl.proc_addr_strobe_n = 1'b1;
      ctrl.ctrl_addr_strobe_n = 1'b1;
      wr.global_wr_n = 1'b1;
      drv_en = 1'b0;
      tick();
      deselect();
      $display("test writes done");
   endtask

   task automatic t_burst_read(logic [1:0] start);
      data_t want;
      addr = BASE + addr_t'(start);
      sel(1'b1);
      ctrl.proc_addr_strobe_n = 1'b0;
      output_enable_n = 1'b0;
      tick();
      check_bit(dq_oe, 1'b0, "first read clock");
      ctrl.proc_addr_strobe_n = 1'b1;
      ctrl.burst_step_n = 1'b0;
      for (int k = 1; k <= 5; k++) begin
         tick();
         // Third step edge: processor strobe with first select high must be ignored
         ctrl.chip_sel_first_n = (k == 2);
         ctrl.proc_addr_strobe_n = (k != 2);
         if (k == 2) addr = 16'h0000;
         want = pat(BASE + addr_t'(nth(start, 2'(k - 1))));
         check_data(dq_out, want, "burst");
         if (k >= 2) check_bit(dq_oe, 1'b1, "read drive");
      end
      ctrl.burst_step_n = 1'b1;
      output_enable_n = 1'b1;
      #1 check_bit(dq_oe, 1'b0, "oe high floats");
      tick();
      output_enable_n = 1'b0;
      #1 check_bit(dq_oe, 1'b1, "oe low drives");
      tick();
      deselect();
      output_enable_n = 1'b1;
      tick();
      $display("test burst read done");
   endtask

   task automatic t_sleep();
      int n;
      addr = BASE;
      sel(1'b1);
      ctrl.proc_addr_strobe_n = 1'b0;
      output_enable_n = 1'b0;
      tick();
      ctrl.proc_addr_strobe_n = 1'b1;
      repeat (2) tick();
      sleep_request = 1'b1;
      #1 check_bit(dq_oe, 1'b0, "sleep floats at once");
      n = 0;
      while (sleeping !== 1'b1 && n < 10) begin
         tick();
         n++;
      end
      check_bit(sleeping, 1'b1, "sleep entered");
      sleep_request = 1'b0;
      output_enable_n = 1'b1;
      n = 0;
      while (sleeping !== 1'b0 && n < 10) begin
         tick();
         n++;
      end
      check_bit(sleeping, 1'b0, "sleep left");
      tick();
      $display("test sleep done");
   endtask

   initial begin
      do_reset(1'b0);
      t_writes();
      t_burst_read(2'h2);
      t_sleep();
      // Contents kept through sleep and reset
      t_burst_read(2'h0);
      do_reset(1'b1);
      t_burst_read(2'h1);
      t_burst_read(2'h3);
      conclude();
   end
endmodule
